// ### rtl/irm_buf.sv
// Small FIFO between the match filter and the packet sink.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module irm_buf #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Count is one bit wider than the pointers, so the full value needs that width too
  assign o_in_ready = cnt_q != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_q != '0;
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign wr_d = !push ? wr_q : (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
  assign rd_d = !pop ? rd_q : (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Data words need no reset; valid is carried by the count
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  property p_no_overfill;
    @(posedge i_clk) disable iff (i_rst)
      cnt_q <= (AW+1)'(DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("buffer count above depth");
endmodule

// ### rtl/irm_filter.sv
// Four isochronous receive contexts: pointer, match and control registers,
// start-on-cycle sequencing and per-packet acceptance filtering.
// Assumes an APB master, a descriptor engine that loads the pointers and
// a link receive path that streams header-first packet words.
//
// Function
// R1: Each context keeps a 32-bit pointer, read-only to software, and a fetch starts when run is set.
// R2: Four contexts 0..3 whose registers repeat every 32 bytes.
// R3: Match bits 31..28 enable tags 11b, 10b, 01b, 00b and only enabled tags are taken.
// R4: Match bits 26..12 hold the 15-bit start cycle, two seconds bits over the 13-bit cycle count.
// R5: With start-on-cycle enabled a context starts receiving only when the timer equals the start cycle.
// R6: Match bits 11..8 hold a marker compared with the packet sync field while the descriptor waits on sync.
// R7: With bit 6 and the tag-01b enable set, a tag-01b packet needs sync bits 3..2 equal to 00b.
// R8: Other tags, or all tags with bit 6 clear, are filtered by their tag enables alone.
// R9: Match bits 5..0 hold the channel taken in single-channel mode.
// R10: Match bits 27 and 7 read zero and ignore writes.
// R11: In multi-channel mode the channel field is ignored and the channel mask decides.
// R12: Software keeps multi-channel mode steady while running and sets it on one context only.
// R13: A packet is taken only when channel, tag and any sync checks all pass.
// R14: Software programs all match fields before setting run.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module irm_filter (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [15:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_PTR_WE,
  input wire logic [1:0] I_PTR_CTX,
  input wire logic [31:0] I_PTR_DATA,
  input wire logic [31:0] I_CYCLE_TIMER,
  input wire logic [63:0] I_CHAN_MASK,
  input wire logic [irm_pkg::NUM_CTX-1:0] I_WAIT_SYNC,
  input wire logic I_PKT_VALID,
  output logic O_PKT_READY,
  input wire logic I_PKT_FIRST,
  input wire logic I_PKT_LAST,
  input wire logic [31:0] I_PKT_DATA,
  output logic [irm_pkg::NUM_CTX-1:0] O_FETCH_REQ,
  output logic [32*irm_pkg::NUM_CTX-1:0] O_FETCH_PTR,
  output logic [irm_pkg::NUM_CTX-1:0] O_ACTIVE,
  output logic O_OUT_VALID,
  input wire logic I_OUT_READY,
  output logic [31:0] O_OUT_DATA,
  output logic O_OUT_LAST,
  output logic [irm_pkg::NUM_CTX-1:0] O_OUT_CTX
);
  import irm_pkg::*;

  // Context bits of the address are masked off before comparing
  function automatic irm_reg_kind_type reg_kind(input logic [15:0] addr);
    logic [15:0] base;
    base = addr & ~CTX_SEL_MASK;
    if (base == OFS_CTRL) begin
      reg_kind = RK_CTRL;
    end else if (base == OFS_PTR) begin
      reg_kind = RK_PTR;
    end else if (base == OFS_MATCH) begin
      reg_kind = RK_MATCH;
    end else begin
      reg_kind = RK_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  irm_reg_kind_type kind;
  logic [1:0] sel_ctx;
  logic apb_setup, apb_access, apb_wr;
  logic [31:0] strb_mask, rd_word;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] ctrl_rd [NUM_CTX];
  logic [31:0] match_q [NUM_CTX];
  logic [31:0] ptr_q [NUM_CTX];

  assign kind = reg_kind(I_PADDR); // R2
  assign sel_ctx = I_PADDR[CTX_SEL_LO +: 2]; // R2
  assign apb_setup = I_PSEL & ~I_PENABLE;
  assign apb_access = I_PSEL & I_PENABLE;
  assign apb_wr = apb_access & I_PWRITE;
  assign strb_mask = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}}, {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
  assign rd_word = (kind == RK_CTRL) ? ctrl_rd[sel_ctx] :
                   (kind == RK_PTR) ? ptr_q[sel_ctx] :
                   (kind == RK_MATCH) ? (match_q[sel_ctx] & MATCH_WMASK) : RESET_WORD; // R10
  // Read data captured in setup so the zero-wait access phase sees a flop
  assign prdata_d = (apb_setup & ~I_PWRITE) ? rd_word : prdata_q;
  assign O_PRDATA = prdata_q;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = apb_access & (kind == RK_NONE);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      prdata_q <= RESET_WORD;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Packet header fields, valid on the first word of a packet
  logic [1:0] hdr_tag;
  logic [5:0] hdr_chan;
  logic [3:0] hdr_sync;
  logic [NUM_CTX-1:0] hdr_accept, held_q, held_d, beat_mask;
  logic [NUM_CTX-1:0] run_q, start_en_q, multi_q, fetch_q;
  logic buf_in_ready, beat_taken;

  assign hdr_tag = I_PKT_DATA[HDR_TAG_LO +: 2];
  assign hdr_chan = I_PKT_DATA[HDR_CHAN_LO +: 6];
  assign hdr_sync = I_PKT_DATA[HDR_SYNC_LO +: 4];

  ////////////////////////////////////////////////////////////////////////
  // Per-context registers and sequencing
  generate
    for (genvar n = 0; n < NUM_CTX; n++) begin : g_ctx
      irm_state_type state_q, state_d;
      logic wr_ctrl, wr_match, wr_ptr, timer_hit, run_rise;
      logic chan_ok, code_ok, filt_on, filt_ok, mark_ok;
      logic [31:0] ctrl_wm, match_wm, ctrl_new, match_d;

      assign wr_ctrl = apb_wr & (kind == RK_CTRL) & (sel_ctx == 2'(n));
      assign wr_match = apb_wr & (kind == RK_MATCH) & (sel_ctx == 2'(n));
      assign wr_ptr = I_PTR_WE & (I_PTR_CTX == 2'(n)); // R1
      assign ctrl_wm = strb_mask & CTRL_WMASK;
      assign match_wm = strb_mask & MATCH_WMASK; // R10
      assign ctrl_new = (ctrl_rd[n] & ~ctrl_wm) | (I_PWDATA & ctrl_wm);
      assign match_d = wr_match ? ((match_q[n] & ~match_wm) | (I_PWDATA & match_wm)) : match_q[n];
      assign run_rise = wr_ctrl & ctrl_new[CB_RUN] & ~run_q[n]; // R1
      assign ctrl_rd[n] = (32'(start_en_q[n]) << CB_START_EN) | (32'(multi_q[n]) << CB_MULTI) |
                          (32'(run_q[n]) << CB_RUN) | (32'(state_q != ST_IDLE) << CB_ACTIVE);
      assign timer_hit = I_CYCLE_TIMER[CT_HI:CT_LO] == match_q[n][MB_CYC_HI:MB_CYC_LO]; // R4

      always_comb begin
        state_d = state_q;
        unique case (state_q)
          ST_IDLE: begin
            if (run_q[n]) begin
              state_d = start_en_q[n] ? ST_WAIT : ST_RUN;
            end
          end
          ST_WAIT: begin
            if (!run_q[n]) begin
              state_d = ST_IDLE;
            end else if (timer_hit) begin
              state_d = ST_RUN; // R5
            end
          end
          ST_RUN: begin
            if (!run_q[n]) begin
              state_d = ST_IDLE;
            end
          end
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end

      // Acceptance of one packet header by this context
      assign chan_ok = multi_q[n] ? I_CHAN_MASK[hdr_chan] :
                       (hdr_chan == match_q[n][MB_CHAN_HI:MB_CHAN_LO]); // R9 R11
      assign code_ok = match_q[n][MB_CODE00 + int'(hdr_tag)]; // R3 R8
      assign filt_on = match_q[n][MB_FILT] & match_q[n][MB_CODE01] & (hdr_tag == CODE_01); // R8
      assign filt_ok = ~filt_on | (hdr_sync[3:2] == SYNC_TOP_ZERO); // R7
      assign mark_ok = ~I_WAIT_SYNC[n] | (hdr_sync == match_q[n][MB_MARK_HI:MB_MARK_LO]); // R6
      assign hdr_accept[n] = (state_q == ST_RUN) & chan_ok & code_ok & filt_ok & mark_ok; // R13
      assign O_ACTIVE[n] = state_q == ST_RUN;
      assign O_FETCH_PTR[n*32 +: 32] = ptr_q[n];

      always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
          state_q <= ST_IDLE;
          run_q[n] <= 1'b0;
          start_en_q[n] <= 1'b0;
          multi_q[n] <= 1'b0;
          fetch_q[n] <= 1'b0;
          match_q[n] <= RESET_WORD;
          ptr_q[n] <= RESET_WORD;
        end else begin
          state_q <= state_d;
          run_q[n] <= wr_ctrl ? ctrl_new[CB_RUN] : run_q[n];
          start_en_q[n] <= wr_ctrl ? ctrl_new[CB_START_EN] : start_en_q[n];
          multi_q[n] <= wr_ctrl ? ctrl_new[CB_MULTI] : multi_q[n]; // R12
          fetch_q[n] <= run_rise; // R1
          match_q[n] <= match_d;
          ptr_q[n] <= wr_ptr ? I_PTR_DATA : ptr_q[n]; // R1
        end
      end

      property p_fetch_on_run;
        @(posedge I_CLOCK) disable iff (I_RST)
          run_rise |=> fetch_q[n] ##1 !fetch_q[n];
      endproperty
      a_fetch_on_run: assert property (p_fetch_on_run) else $error("fetch pulse missing after run set"); // R1

      property p_ptr_load;
        @(posedge I_CLOCK) disable iff (I_RST)
          wr_ptr |=> ptr_q[n] == $past(I_PTR_DATA);
      endproperty
      a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R1

      property p_stop_idle;
        @(posedge I_CLOCK) disable iff (I_RST)
          !run_q[n] |=> state_q == ST_IDLE;
      endproperty
      a_stop_idle: assert property (p_stop_idle) else $error("context kept going after run cleared"); // R1

      property p_code_gate;
        @(posedge I_CLOCK) disable iff (I_RST)
          hdr_accept[n] |-> match_q[n][MB_CODE00 + int'(hdr_tag)];
      endproperty
      a_code_gate: assert property (p_code_gate) else $error("disabled tag accepted"); // R3

      property p_start_direct;
        @(posedge I_CLOCK) disable iff (I_RST)
          (state_q == ST_IDLE) && run_q[n] && !start_en_q[n] |=> O_ACTIVE[n];
      endproperty
      a_start_direct: assert property (p_start_direct) else $error("no start without cycle wait"); // R5

      property p_wait_cycle;
        @(posedge I_CLOCK) disable iff (I_RST)
          (state_q == ST_WAIT) && run_q[n] && !timer_hit |=> state_q == ST_WAIT;
      endproperty
      a_wait_cycle: assert property (p_wait_cycle) else $error("left wait early"); // R5

      property p_start_cycle;
        @(posedge I_CLOCK) disable iff (I_RST)
          (state_q == ST_WAIT) && run_q[n] && timer_hit |=> O_ACTIVE[n];
      endproperty
      a_start_cycle: assert property (p_start_cycle) else $error("no start on cycle"); // R4

      property p_marker;
        @(posedge I_CLOCK) disable iff (I_RST)
          hdr_accept[n] && I_WAIT_SYNC[n] |-> hdr_sync == match_q[n][MB_MARK_HI:MB_MARK_LO];
      endproperty
      a_marker: assert property (p_marker) else $error("sync marker mismatch accepted"); // R6

      property p_filter01;
        @(posedge I_CLOCK) disable iff (I_RST)
          hdr_accept[n] && match_q[n][MB_FILT] && hdr_tag == CODE_01 |-> hdr_sync[3:2] == SYNC_TOP_ZERO;
      endproperty
      a_filter01: assert property (p_filter01) else $error("tag 01 sync filter bypassed"); // R7

      property p_single_chan;
        @(posedge I_CLOCK) disable iff (I_RST)
          hdr_accept[n] && !multi_q[n] |-> hdr_chan == match_q[n][MB_CHAN_HI:MB_CHAN_LO];
      endproperty
      a_single_chan: assert property (p_single_chan) else $error("wrong channel accepted"); // R9

      property p_multi_chan;
        @(posedge I_CLOCK) disable iff (I_RST)
          hdr_accept[n] && multi_q[n] |-> I_CHAN_MASK[hdr_chan];
      endproperty
      a_multi_chan: assert property (p_multi_chan) else $error("masked channel accepted"); // R11

      property p_idle_quiet;
        @(posedge I_CLOCK) disable iff (I_RST)
          !run_q[n] ##1 !run_q[n] |-> !hdr_accept[n];
      endproperty
      a_idle_quiet: assert property (p_idle_quiet) else $error("stopped context accepted"); // R13
    end
  endgenerate

  assign O_FETCH_REQ = fetch_q;

  property p_rsvd_zero;
    @(posedge I_CLOCK) disable iff (I_RST)
      apb_setup && !I_PWRITE && kind == RK_MATCH ##1 apb_access |-> !O_PRDATA[27] && !O_PRDATA[7];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved match bits read nonzero"); // R10

  ////////////////////////////////////////////////////////////////////////
  // Packet stream; the header decision is held for the rest of the packet
  assign beat_mask = I_PKT_FIRST ? hdr_accept : held_q;
  assign beat_taken = I_PKT_VALID & buf_in_ready;
  assign held_d = (beat_taken & I_PKT_FIRST) ? hdr_accept : held_q;
  // Dropped words still wait for buffer room, trading rate for simplicity
  assign O_PKT_READY = buf_in_ready;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      held_q <= '0;
    end else begin
      held_q <= held_d;
    end
  end

  irm_buf #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_in_valid(I_PKT_VALID & (|beat_mask)),
    .o_in_ready(buf_in_ready),
    .i_in_data({beat_mask, I_PKT_LAST, I_PKT_DATA}),
    .o_out_valid(O_OUT_VALID),
    .i_out_ready(I_OUT_READY),
    .o_out_data({O_OUT_CTX, O_OUT_LAST, O_OUT_DATA})
  );
endmodule

// ### rtl/irm_pkg.sv
// Constants and types of the isochronous receive context match filter.
// Assumes a 32-bit APB register bus and 1394 isochronous header words.
package irm_pkg;

  localparam int NUM_CTX = 4;

  ////////////////////////////////////////////////////////////////////////
  // Register map; bits 6:5 of the address pick the context (stride 32)
  localparam logic [15:0] OFS_CTRL = 16'h0400;
  localparam logic [15:0] OFS_PTR = 16'h040C;
  localparam logic [15:0] OFS_MATCH = 16'h410C;
  localparam logic [15:0] CTX_SEL_MASK = 16'h0060;
  localparam int CTX_SEL_LO = 5;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Match register fields
  localparam int MB_CODE00 = 28;
  localparam int MB_CODE01 = 29;
  localparam int MB_CYC_HI = 26;
  localparam int MB_CYC_LO = 12;
  localparam int MB_MARK_HI = 11;
  localparam int MB_MARK_LO = 8;
  localparam int MB_FILT = 6;
  localparam int MB_CHAN_HI = 5;
  localparam int MB_CHAN_LO = 0;
  localparam logic [31:0] MATCH_WMASK = 32'hF7FF_FF7F;

  ////////////////////////////////////////////////////////////////////////
  // Context control register fields
  localparam int CB_START_EN = 29;
  localparam int CB_MULTI = 28;
  localparam int CB_RUN = 15;
  localparam int CB_ACTIVE = 10;
  localparam logic [31:0] CTRL_WMASK = 32'h3000_8000;

  ////////////////////////////////////////////////////////////////////////
  // Cycle timer and packet header fields
  localparam int CT_LO = 12;
  localparam int CT_HI = 26;
  localparam int HDR_TAG_LO = 14;
  localparam int HDR_CHAN_LO = 8;
  localparam int HDR_SYNC_LO = 0;
  localparam logic [1:0] CODE_01 = 2'h1;
  localparam logic [1:0] SYNC_TOP_ZERO = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Output buffer
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 32 + 1 + NUM_CTX;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } irm_state_type;

  typedef enum logic [1:0] {
    RK_NONE,
    RK_CTRL,
    RK_PTR,
    RK_MATCH
  } irm_reg_kind_type;

endpackage

// ### tb/irm_link_model.sv
// Link receive path model: delivers isochronous packet words one at a time, with first and last flags.
// Assumes the filter samples valid and answers ready on rising edges.
`timescale 1ns/100ps
module irm_link_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic o_first,
  output logic o_last,
  output logic [31:0] o_data,
  output logic o_timeout
);
  initial begin
    o_valid = 1'b0;
    o_first = 1'b0;
    o_last = 1'b0;
    o_data = 32'h0000_0000;
    o_timeout = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Word held until taken or for 50 cycles at most; gap models a slow link
  task automatic send(input logic [31:0] hdr, input int gap, input logic fst, input logic lst);
    int i;
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_first <= fst;
    o_last <= lst;
    o_data <= hdr;
    for (i = 0; i < 50; i++) begin
      @(posedge i_clk);
      if (i_ready === 1'b1) break;
    end
    if (i == 50) o_timeout <= 1'b1;
    // Released bus must not look like a held word
    o_valid <= 1'b0;
    o_first <= ~fst;
    o_last <= ~lst;
    o_data <= ~hdr;
  endtask
endmodule

// ### tb/test_irm_filter.sv
// Self-checking bench of the receive context match filter.
// Assumes the link model beside it and zero-wait APB answers.
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value %s: expected %h, seen %h", nm, exp, got); end end
module test_irm_filter;
  import irm_pkg::*;
  logic I_CLOCK = 1'b0, I_RST = 1'b1, I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
  logic [15:0] I_PADDR = 16'h0000;
  logic [31:0] I_PWDATA = 32'h0000_0000, I_PTR_DATA = 32'h0000_0000, I_CYCLE_TIMER = 32'h0000_0000;
  logic [3:0] I_PSTRB = 4'hF, I_WAIT_SYNC = 4'h0;
  logic I_PTR_WE = 1'b0, I_OUT_READY = 1'b0;
  logic [1:0] I_PTR_CTX = 2'h0;
  logic [63:0] I_CHAN_MASK = 64'h0000_0000_0000_0080;
  logic [31:0] O_PRDATA, O_OUT_DATA, rd;
  logic [127:0] O_FETCH_PTR;
  logic [3:0] O_FETCH_REQ, O_ACTIVE, O_OUT_CTX;
  logic O_PREADY, O_PSLVERR, O_PKT_READY, O_OUT_VALID, O_OUT_LAST, err;
  logic pkt_valid, pkt_first, pkt_last, link_to;
  logic [31:0] pkt_data;
  int mismatches = 0, num_checks = 0, n, e, t;

  initial forever #25 I_CLOCK = ~I_CLOCK;

  irm_filter uut (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_PTR_WE(I_PTR_WE),
    .I_PTR_CTX(I_PTR_CTX), .I_PTR_DATA(I_PTR_DATA), .I_CYCLE_TIMER(I_CYCLE_TIMER),
    .I_CHAN_MASK(I_CHAN_MASK), .I_WAIT_SYNC(I_WAIT_SYNC), .I_PKT_VALID(pkt_valid),
    .O_PKT_READY(O_PKT_READY), .I_PKT_FIRST(pkt_first), .I_PKT_LAST(pkt_last),
    .I_PKT_DATA(pkt_data), .O_FETCH_REQ(O_FETCH_REQ), .O_FETCH_PTR(O_FETCH_PTR),
    .O_ACTIVE(O_ACTIVE), .O_OUT_VALID(O_OUT_VALID), .I_OUT_READY(I_OUT_READY),
    .O_OUT_DATA(O_OUT_DATA), .O_OUT_LAST(O_OUT_LAST), .O_OUT_CTX(O_OUT_CTX));

  irm_link_model link (.i_clk(I_CLOCK), .i_ready(O_PKT_READY), .o_valid(pkt_valid),
    .o_first(pkt_first), .o_last(pkt_last), .o_data(pkt_data), .o_timeout(link_to));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int i;
    @(posedge I_CLOCK);
    I_PSEL <= 1'b1;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= wd;
    @(posedge I_CLOCK);
    I_PENABLE <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge I_CLOCK);
      if (O_PREADY === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      end_of_test();
    end
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, exp, rd)
  endtask

  // Output held back until looked at; exp 0 means the packet is dropped
  task automatic take(input logic [3:0] exp, input logic [31:0] xd, input logic xl);
    int i;
    for (i = 0; i < 6; i++) begin
      @(posedge I_CLOCK);
      if (O_OUT_VALID === 1'b1) break;
    end
    `CHK("out ctx", exp, (i == 6) ? 4'h0 : O_OUT_CTX)
    if (i < 6) begin
      `CHK("out data", xd, O_OUT_DATA)
      `CHK("out last", xl, O_OUT_LAST)
      I_OUT_READY <= 1'b1;
      @(posedge I_CLOCK);
      I_OUT_READY <= 1'b0;
    end
  endtask

  task automatic pkt(input logic [1:0] tg, input logic [5:0] ch, input logic [3:0] sy, input logic [3:0] exp);
    logic [31:0] w;
    w = {16'h0000, tg, ch, 4'h0, sy};
    link.send(w, 0, 1'b1, 1'b1);
    take(exp, w, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    @(posedge I_CLOCK);
    I_PTR_WE <= 1'b1;
    I_PTR_CTX <= 2'h2;
    I_PTR_DATA <= 32'hA5A5_0040;
    @(posedge I_CLOCK);
    I_PTR_WE <= 1'b0;
    apb(1'b1, OFS_PTR + 16'h0040, 32'h0000_0000);
    rd_chk("ptr ctx2", OFS_PTR + 16'h0040, 32'hA5A5_0040);
    `CHK("fetch ptr ctx2", 32'hA5A5_0040, O_FETCH_PTR[95:64])
    rd_chk("unmapped", 16'h0000, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, err)
    for (n = 0; n < 4; n++) begin
      apb(1'b1, OFS_MATCH + 16'(32 * n), 32'hFFFF_FFFF);
      rd_chk("match ro bits", OFS_MATCH + 16'(32 * n), 32'hF7FF_FF7F);
    end
    // Only byte lane 0 written: channel field and bit 6 cleared, rest kept
    I_PSTRB <= 4'h1;
    apb(1'b1, OFS_MATCH + 16'h0060, 32'h0000_0000);
    I_PSTRB <= 4'hF;
    rd_chk("match byte lane", OFS_MATCH + 16'h0060, 32'hF7FF_FF00);
    // Match fields first, then run
    apb(1'b1, OFS_MATCH, 32'hF000_0005);
    apb(1'b1, OFS_CTRL, 32'h0000_8000);
    #1 `CHK("fetch req", 4'h1, O_FETCH_REQ)
    @(posedge I_CLOCK);
    #1 `CHK("fetch req end", 4'h0, O_FETCH_REQ)
    @(posedge I_CLOCK);
    #1 `CHK("active ctx0", 1'b1, O_ACTIVE[0])
    for (e = 0; e < 4; e++) begin
      apb(1'b1, OFS_MATCH, (32'h1 << (28 + e)) | 32'h5);
      for (t = 0; t < 4; t++) pkt(2'(t), 6'h05, 4'h0, (t == e) ? 4'h1 : 4'h0);
    end
    pkt(2'h3, 6'h06, 4'h0, 4'h0);
    apb(1'b1, OFS_MATCH, 32'hF000_0045);
    pkt(2'h1, 6'h05, 4'h4, 4'h0);
    pkt(2'h1, 6'h05, 4'h3, 4'h1);
    pkt(2'h2, 6'h05, 4'hC, 4'h1);
    apb(1'b1, OFS_MATCH, 32'hF000_0005);
    pkt(2'h1, 6'h05, 4'hC, 4'h1);
    I_WAIT_SYNC <= 4'h1;
    apb(1'b1, OFS_MATCH, 32'hF000_0905);
    pkt(2'h0, 6'h05, 4'h9, 4'h1);
    pkt(2'h0, 6'h05, 4'h8, 4'h0);
    I_WAIT_SYNC <= 4'h0;
    // Mode bit only changed while stopped
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h1000_0000);
    apb(1'b1, OFS_CTRL, 32'h1000_8000);
    repeat (2) @(posedge I_CLOCK);
    pkt(2'h0, 6'h07, 4'h0, 4'h1);
    pkt(2'h0, 6'h05, 4'h0, 4'h0);
    link.send(32'h0000_0700, 0, 1'b1, 1'b1);
    link.send(32'h0000_0701, 3, 1'b1, 1'b1);
    @(posedge I_CLOCK);
    `CHK("pkt ready full", 1'b0, O_PKT_READY)
    take(4'h1, 32'h0000_0700, 1'b1);
    take(4'h1, 32'h0000_0701, 1'b1);
    // Body word looks like a header with the opposite verdict; the held decision must win
    link.send(32'h0000_0700, 0, 1'b1, 1'b0);
    link.send(32'h0000_0500, 0, 1'b0, 1'b1);
    take(4'h1, 32'h0000_0700, 1'b0);
    take(4'h1, 32'h0000_0500, 1'b1);
    link.send(32'h0000_0500, 0, 1'b1, 1'b0);
    link.send(32'h0000_0700, 0, 1'b0, 1'b1);
    take(4'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, OFS_MATCH + 16'h0020, 32'h0123_4000);
    apb(1'b1, OFS_CTRL + 16'h0020, 32'h2000_8000);
    repeat (4) @(posedge I_CLOCK);
    rd_chk("ctrl ctx1 waiting", OFS_CTRL + 16'h0020, 32'h2000_8400);
    `CHK("active ctx1 early", 1'b0, O_ACTIVE[1])
    I_CYCLE_TIMER <= 32'h0123_4000;
    repeat (3) @(posedge I_CLOCK);
    #1 `CHK("active ctx1", 1'b1, O_ACTIVE[1])
    `CHK("link timeout", 1'b0, link_to)
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge I_CLOCK);
    mismatches++;
    end_of_test();
  end
endmodule
